// File: rtl/mpsc_pkg.sv
package mpsc_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 10000;
  localparam int BOOT_MAX_NS = 1200000;   // longest booting time, 1.2 ms in ns
  localparam int BOOT_MAX_US = 1200;
  // longest time rounds down
  localparam int BOOT_CYCLES = (BOOT_MAX_US * 1000000) / CLK_PERIOD_PS;

  // ----------------------------------------------------------------
  // power states, gray coded along off-boot-active-standby
  // ----------------------------------------------------------------
  typedef enum logic [1:0]
  {
    MPSC_OFF = 2'h0,
    MPSC_BOOT = 2'h1,
    MPSC_ACTIVE = 2'h3,
    MPSC_STANDBY = 2'h2
  } mpsc_state_e;

  // status field positions
  localparam int STAT_ACTIVE_BIT = 0;
  localparam int STAT_T_BIT = 1;
  localparam int STAT_H_BIT = 2;
  localparam int STAT_W = 3;

endpackage

// File: rtl/mpsc_power_ctrl.sv
`timescale 1ns/10ps

// How it works
// - in standby the measurement engine power is off while host-side ports keep working.
// - a measurement request passes boot then active before the measurement starts.
// - after a measurement completes the block returns to standby, results stay held.
// - continuous mode or disabled low power keeps the block in active.
// - whether the block is active is shown on a status output, one cycle after the state.
// - after reset the block boots to active then drops straight to standby.
// - booting ends by itself within the booting time of 1.2 ms.
// - temperature runs a coarse search then a sigma-delta phase, giving 12 bits.
// - the temperature result is handed on as a calibrated Kelvin value.
// - humidity comes from a second-order sigma-delta capacitance converter.
// - humidity results are passed on only after temperature compensation.
// - the host link is standard I2C at standard and fast speed, handled outside.
// - in single-shot mode a started sensor stops once its measurement completes.
module mpsc_power_ctrl
  import mpsc_pkg::*;
#(
  parameter int BOOT_LEN = BOOT_CYCLES
)
(
  input wire logic mclk, // system clock
  input wire logic sys_rst, // async reset, high
  input wire logic measurement_trigger_t, // start temperature, pulse
  input wire logic measurement_trigger_h, // start humidity, pulse
  input wire logic continuous_mode_select, // continuous run mode
  input wire logic system_power_control, // high: low power enabled
  input wire logic t_conv_done, // temperature engine finished, pulse
  input wire logic h_conv_done, // humidity engine finished, pulse
  output logic engine_power_on, // measurement engine power
  output logic t_run, // temperature conversion running
  output logic h_run, // humidity conversion running
  output logic sys_active, // device active
  output logic [STAT_W-1:0] sensor_activity_status // power and sensor status
);

  // elaboration check: zero never leaves boot; above the default breaks the limit
  if (BOOT_LEN < 1 || BOOT_LEN > BOOT_CYCLES)
  begin : g_boot_len_check
    $error("BOOT_LEN out of range");
  end

  // ----------------------------------------------------------------
  // synchronise the asynchronous host-side control inputs
  // ----------------------------------------------------------------
  logic [3:0] sync1_r;
  logic [3:0] sync2_r;
  logic [1:0] done1_r;
  logic [1:0] done2_r;

  // two stages each; only stage two is read
  // control bits arrive from the host link, which runs outside this block
  // reset to the idle levels: low power on, single shot, no request
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      sync1_r <= 4'h8;
      sync2_r <= 4'h8;
      done1_r <= 2'h0;
      done2_r <= 2'h0;
    end
    else
    begin
      sync1_r <= {system_power_control, continuous_mode_select,
                  measurement_trigger_h, measurement_trigger_t};
      sync2_r <= sync1_r;
      done1_r <= {h_conv_done, t_conv_done};
      done2_r <= done1_r;
    end
  end

  wire trig_t = sync2_r[0];
  wire trig_h = sync2_r[1];
  wire cont_mode = sync2_r[2];
  wire low_pwr_en = sync2_r[3];
  wire done_t = done2_r[0];
  wire done_h = done2_r[1];

  // ----------------------------------------------------------------
  // state decode
  // ----------------------------------------------------------------
  // engine supply follows boot and active; shared by the output and a check
  function automatic logic state_powered(input mpsc_state_e s);
    return (s == MPSC_BOOT) || (s == MPSC_ACTIVE);
  endfunction

  // ----------------------------------------------------------------
  // pending requests
  // ----------------------------------------------------------------
  mpsc_state_e state_r;
  mpsc_state_e state_nxt;
  logic pend_t_r;
  logic pend_h_r;
  logic t_run_r;
  logic h_run_r;
  logic t_sel_r;
  logic h_sel_r;
  logic [31:0] boot_cnt_r;

  // state decode as named wires
  wire in_boot = (state_r == MPSC_BOOT);
  wire in_active = (state_r == MPSC_ACTIVE);
  wire in_standby = (state_r == MPSC_STANDBY);

  wire boot_done = in_boot && (boot_cnt_r >= 32'(BOOT_LEN - 1));
  // a sensor is busy until its own done; the step waits for both
  wire busy_t = t_run_r && !done_t;
  wire busy_h = h_run_r && !done_h;
  wire step_end = in_active && !busy_t && !busy_h;
  // launch consumes pending requests at a step boundary
  wire launch = step_end && (pend_t_r || pend_h_r);
  // continuous runs re-launch the sensors that took part in the last step
  wire relaunch_t = step_end && cont_mode && t_sel_r;
  wire relaunch_h = step_end && cont_mode && h_sel_r;
  wire stay_active = cont_mode || !low_pwr_en || launch;
  // sensors started at this step boundary
  wire start_t = (launch && pend_t_r) || relaunch_t;
  wire start_h = (launch && pend_h_r) || relaunch_h;

  // requests wait while booting or measuring; set beats consume
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      pend_t_r <= 1'b0;
      pend_h_r <= 1'b0;
    end
    else
    begin
      pend_t_r <= trig_t || (pend_t_r && !launch);
      pend_h_r <= trig_h || (pend_h_r && !launch);
    end
  end

  // ----------------------------------------------------------------
  // power state machine
  // ----------------------------------------------------------------
  // standby wakes on request, boot is transient
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      MPSC_OFF: state_nxt = MPSC_BOOT;
      MPSC_BOOT: if (boot_done) state_nxt = MPSC_ACTIVE;
      MPSC_ACTIVE: if (step_end && !stay_active) state_nxt = MPSC_STANDBY;
      MPSC_STANDBY:
        if (pend_t_r || pend_h_r || cont_mode || !low_pwr_en) state_nxt = MPSC_BOOT;
      default: state_nxt = MPSC_OFF;
    endcase
  end

  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
      state_r <= MPSC_OFF;
    else
      state_r <= state_nxt;
  end

  // boot counter, cleared outside booting
  // 32 bits hold any legal BOOT_LEN; a request in boot never restarts it
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
      boot_cnt_r <= 32'h0;
    else if (in_boot)
      boot_cnt_r <= boot_cnt_r + 32'h1;
    else
      boot_cnt_r <= 32'h0;
  end

  // ----------------------------------------------------------------
  // conversion run flags
  // ----------------------------------------------------------------
  // start only once active; single-shot stops on done
  // the engine itself does coarse search plus sigma-delta
  // each flag drops on its own done, so a sensor that finished first
  // is not run again while the other one is still converting
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      t_run_r <= 1'b0;
      h_run_r <= 1'b0;
    end
    else if (step_end)
    begin
      t_run_r <= start_t;
      h_run_r <= start_h;
    end
    else
    begin
      if (done_t)
        t_run_r <= 1'b0;
      if (done_h)
        h_run_r <= 1'b0;
    end
  end

  // which sensors belong to the current step, kept for continuous relaunch
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      t_sel_r <= 1'b0;
      h_sel_r <= 1'b0;
    end
    else if (step_end)
    begin
      t_sel_r <= start_t;
      h_sel_r <= start_h;
    end
  end

  // ----------------------------------------------------------------
  // outputs, all registered
  // ----------------------------------------------------------------
  // engine is off in off and standby; host side unaffected
  // results (kelvin, compensated rh) stay in engine registers
  // status trails the state by one cycle, the price of registered outputs
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      engine_power_on <= 1'b0;
      sys_active <= 1'b0;
      t_run <= 1'b0;
      h_run <= 1'b0;
      sensor_activity_status <= '0;
    end
    else
    begin
      engine_power_on <= state_powered(state_nxt);
      sys_active <= in_active;
      t_run <= t_run_r;
      h_run <= h_run_r;
      sensor_activity_status[STAT_ACTIVE_BIT] <= in_active;
      sensor_activity_status[STAT_T_BIT] <= t_run_r;
      sensor_activity_status[STAT_H_BIT] <= h_run_r;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_standby_unpowered: assert property (@(posedge mclk) disable iff (sys_rst)
    in_standby |-> !engine_power_on)
    else $error("engine powered in standby");

  a_run_needs_active: assert property (@(posedge mclk) disable iff (sys_rst)
    $rose(t_run_r) |-> $past(state_r) == MPSC_ACTIVE)
    else $error("conversion started outside active");

  a_boot_bounded: assert property (@(posedge mclk) disable iff (sys_rst)
    state_r == MPSC_BOOT |-> boot_cnt_r < 32'(BOOT_LEN))
    else $error("boot too long");

  a_cont_stays: assert property (@(posedge mclk) disable iff (sys_rst)
    state_r == MPSC_ACTIVE && cont_mode |=> state_r == MPSC_ACTIVE)
    else $error("left active in continuous mode");

  a_status_tracks: assert property (@(posedge mclk) disable iff (sys_rst)
    ##1 sensor_activity_status[STAT_ACTIVE_BIT] == ($past(state_r) == MPSC_ACTIVE))
    else $error("status wrong");

  a_reset_boots: assert property (@(posedge mclk) disable iff (sys_rst)
    state_r == MPSC_OFF |=> state_r == MPSC_BOOT)
    else $error("no boot after reset");

  a_single_stops: assert property (@(posedge mclk) disable iff (sys_rst)
    step_end && !cont_mode && !launch |=> !t_run_r && !h_run_r)
    else $error("single shot did not stop");

  a_standby_end: assert property (@(posedge mclk) disable iff (sys_rst)
    step_end && !stay_active |=> state_r == MPSC_STANDBY)
    else $error("no return to standby");

  a_req_held: assert property (@(posedge mclk) disable iff (sys_rst)
    pend_t_r && !launch |=> pend_t_r)
    else $error("pending request lost");

  a_power_matches: assert property (@(posedge mclk) disable iff (sys_rst)
    engine_power_on == state_powered(state_r))
    else $error("engine power does not follow the state");

  a_standby_idle: assert property (@(posedge mclk) disable iff (sys_rst)
    in_standby |-> !t_run_r && !h_run_r)
    else $error("conversion running in standby");

  a_wake_boots: assert property (@(posedge mclk) disable iff (sys_rst)
    in_standby && (pend_t_r || pend_h_r) |=> in_boot)
    else $error("request did not wake the engine");

  a_lowpwr_stays: assert property (@(posedge mclk) disable iff (sys_rst)
    in_active && !low_pwr_en |=> in_active)
    else $error("left active with low power disabled");

  a_cont_relaunch: assert property (@(posedge mclk) disable iff (sys_rst)
    step_end && cont_mode && t_sel_r |=> t_run_r)
    else $error("continuous run not repeated");

  a_status_sensors: assert property (@(posedge mclk) disable iff (sys_rst)
    ##1 sensor_activity_status[STAT_T_BIT] == $past(t_run_r)
    && sensor_activity_status[STAT_H_BIT] == $past(h_run_r))
    else $error("sensor status wrong");

  a_done_stops: assert property (@(posedge mclk) disable iff (sys_rst)
    t_run_r && done_t && !step_end |=> !t_run_r)
    else $error("temperature run kept after done");

  a_boot_counts: assert property (@(posedge mclk) disable iff (sys_rst)
    in_boot && !boot_done |=> in_boot && boot_cnt_r == $past(boot_cnt_r) + 32'h1)
    else $error("boot restarted or stalled");

  // ----------------------------------------------------------------
  // covers for the main scenarios
  // ----------------------------------------------------------------
  c_single_shot: cover property (@(posedge mclk) disable iff (sys_rst)
    $fell(t_run_r) ##[1:5] state_r == MPSC_STANDBY);
  c_wake: cover property (@(posedge mclk) disable iff (sys_rst)
    state_r == MPSC_STANDBY ##1 state_r == MPSC_BOOT);
  c_both: cover property (@(posedge mclk) disable iff (sys_rst) t_run_r && h_run_r);
  c_relaunch: cover property (@(posedge mclk) disable iff (sys_rst)
    step_end && relaunch_t);
  c_req_in_boot: cover property (@(posedge mclk) disable iff (sys_rst)
    in_boot && (trig_t || trig_h));

endmodule

// File: testbench/mpsc_engine_model.sv
`timescale 1ns/10ps

// -------------------------------------------------------
// conversion engine stand-in, one per sensor
// -------------------------------------------------------
module mpsc_engine_model
(
  input wire logic mclk, // system clock
  input wire logic run, // conversion requested
  output logic done // one-cycle finish pulse
);
  // latency drawn each time, so prompt and slow finishes both occur
  initial done = 1'b0;
  always
  begin
    @(posedge mclk);
    if (run === 1'b1)
    begin
      repeat (3 + $urandom_range(12)) @(posedge mclk);
      done <= 1'b1;
      @(posedge mclk);
      done <= 1'b0;
      // run flag drops a few cycles after done, so do not finish twice
      repeat (5) @(posedge mclk);
    end
  end
endmodule

// File: testbench/mpsc_power_ctrl_tb.sv
`timescale 1ns/10ps

module mpsc_power_ctrl_tb;
  import mpsc_pkg::*;
  localparam int BL = 8;
  logic mclk = 0, sys_rst = 1, trig_t = 0, trig_h = 0, cont = 0, lp = 1, t_done, h_done;
  logic pwr, t_run, h_run, act, run_q = 0, mon_en = 1;
  logic [STAT_W-1:0] stat;
  logic [3:0] notes[$];
  logic [3:0] nt;
  int err_total = 0, samples_checked = 0, n, pulses;

  always #5 mclk = ~mclk;

  mpsc_power_ctrl #(.BOOT_LEN(BL)) mpsc_power_ctrl_inst (.mclk(mclk), .sys_rst(sys_rst),
    .measurement_trigger_t(trig_t), .measurement_trigger_h(trig_h),
    .continuous_mode_select(cont), .system_power_control(lp), .t_conv_done(t_done),
    .h_conv_done(h_done), .engine_power_on(pwr), .t_run(t_run), .h_run(h_run),
    .sys_active(act), .sensor_activity_status(stat));
  mpsc_engine_model t_eng_inst (.mclk(mclk), .run(t_run), .done(t_done));
  mpsc_engine_model h_eng_inst (.mclk(mclk), .run(h_run), .done(h_done));

  // -------------------------------------------------------
  // compare, wait and close
  // -------------------------------------------------------
  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [3:0] exp, input logic [3:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      err_total++;
    end
  endtask

  function automatic logic pick(input int sel);
    case (sel)
      0: pick = act;
      1: pick = pwr;
      default: pick = t_run | h_run;
    endcase
  endfunction

  // bounded wait; n holds the cycles spent
  task automatic wait_sig(input int sel, input logic val, input int lim);
    n = 0;
    while (pick(sel) !== val && n < lim)
    begin
      @(posedge mclk);
      #1 n++;
    end
    if (pick(sel) !== val)
    begin
      chk($sformatf("wait %0d", sel), {3'h0, val}, {3'h0, ~val});
      complete_run();
    end
  endtask

  task automatic pulse(input logic [1:0] code);
    @(posedge mclk);
    #1 {trig_h, trig_t} = code;
    @(posedge mclk);
    #1 {trig_h, trig_t} = 2'h0;
  endtask

  // -------------------------------------------------------
  // monitor: each rising run pattern matches the oldest note
  // -------------------------------------------------------
  always @(posedge mclk)
  begin
    run_q <= t_run | h_run;
    if ((t_run | h_run) === 1'b1 && run_q === 1'b0 && mon_en)
    begin
      nt = (notes.size() > 0) ? notes.pop_front() : 4'hf;
      chk("run start", nt, {pwr, act, h_run, t_run});
    end
  end

  // single step; re repeats the request mid-boot
  task automatic meas(input logic [1:0] code, input bit re);
    notes.push_back({2'b11, code});
    pulse(code);
    if (re)
      pulse(code);
    wait_sig(2, 1'b1, BL + 40);
    @(posedge mclk);
    #1 chk("status", {1'b0, code, 1'b1}, {1'b0, stat});
    wait_sig(2, 1'b0, 60);
    wait_sig(0, 1'b0, 10);
    @(posedge mclk);
    #1 chk("standby", 4'h0, {pwr, act, h_run, t_run});
    repeat (20) @(posedge mclk);
  endtask

  initial
  begin
    void'($urandom(32'h1247b982));
    repeat (16) @(posedge mclk);
    #1 sys_rst = 0;
    wait_sig(1, 1'b1, 5);
    wait_sig(0, 1'b1, BL + 10);
    chk("boot time", 4'h1, {3'h0, n <= BL + 3});
    wait_sig(0, 1'b0, 10);
    #1 chk("power-up", 4'h0, {pwr, stat});
    $display("test power-up done");
    for (int i = 0; i < 7; i++)
      meas((i < 3) ? 2'(i + 1) : 2'($urandom_range(3, 1)), i > 4);
    $display("test single shot done");
    mon_en = 0;
    cont = 1;
    pulse(2'h1);
    wait_sig(0, 1'b1, BL + 40);
    pulses = 0;
    for (int i = 0; i < 80; i++)
    begin
      @(posedge mclk);
      #1 pulses += t_done;
      if (act !== 1'b1)
        chk("cont active", 4'h1, {3'h0, act});
    end
    chk("cont repeats", 4'h1, {3'h0, pulses >= 2});
    cont = 0;
    wait_sig(0, 1'b0, 80);
    $display("test continuous done");
    lp = 0;
    wait_sig(0, 1'b1, BL + 20);
    repeat (40) @(posedge mclk);
    #1 chk("low power off", 4'h3, {2'h0, pwr, act});
    lp = 1;
    wait_sig(0, 1'b0, 20);
    repeat (10) @(posedge mclk);
    #1 mon_en = 1;
    $display("test low power disabled done");
    chk("notes left", 4'h0, 4'(notes.size()));
    complete_run();
  end
endmodule
